// File: verilog/velocity_mode_select.sv
/*
 * Velocity dependent feature selection with direct coil current drive,
 * reached over a 40-bit serial register port.
 * Assumes all inputs synchronous to ref_clk, serial clock much slower than
 * ref_clk, and a step interval measurement that pulses interval_valid.
 */
// Behaviour
// - between lower and upper threshold enable adaptive scaling, disable voltage PWM
// - at or above lower-threshold velocity enable the stall status output
// - outside commutation mode disable stall detection below lower-threshold velocity
// - at or above upper-threshold velocity: no adaptive scaling, no voltage PWM
// - above upper threshold with chopper flag force mode one, fast decay zero
// - above upper threshold switch chopper synchronisation off
// - above upper threshold with fullstep flag: fullstep and commutation stall detection
// - thresholds are 20-bit unsigned step intervals in driver clock units
// - direct select bit zero is normal, one drives coils from register
// - coil A in bits 8..0, coil B in bits 24..16, signed
// - direct mode scales by standstill current, no velocity PWM, no commutation
// - direct mode scaling and stall need external step pulses
// - direct register ignored in standalone step/direction configuration
// - commutation enabled only by input; 23-bit minimum velocity applies
// - minimum velocity time reference is 2^24 driver clocks
// - threshold comparisons use one sixteenth hysteresis
// - at or below pwm-threshold velocity enable voltage PWM, disable commutation
`timescale 1ns/10ps
`include "vsel_params.svh"

module velocity_mode_select (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    input wire logic [19:0] measured_step_interval,
    input wire logic interval_valid,
    input wire logic [19:0] pwm_upper_velocity_threshold,
    input wire vsel_pkg::feature_cfg_t cfg,
    input wire logic commutation_enable_input,
    input wire logic ext_step_active,
    input wire logic elec_period_pulse,
    output vsel_pkg::mode_gates_t gates,
    output vsel_pkg::coil_cmd_t coil_cmd,
    output logic [22:0] min_commutation_velocity
);
    import vsel_pkg::*;

    // ************************************************************
    // functions
    // ************************************************************

    // stay in the fast region up to the threshold, enter it only below
    // threshold*15/16, so the upper switching velocity sits above the setting
    function automatic logic in_fast_region(input logic prev, input logic [19:0] t, input logic [19:0] thr);
        logic [19:0] low;
        low = thr - (thr >> `HYST_SHIFT);
        in_fast_region = prev ? (t <= thr) : (t < low);
    endfunction

    function automatic logic signed [8:0] scale_coil(input logic signed [8:0] c, input logic [4:0] ih);
        logic signed [15:0] p;
        p = 16'(c) * $signed({11'h000, ih} + 16'h0001);
        scale_coil = p[(`ISCALE_SHIFT + 8):`ISCALE_SHIFT];
    endfunction

    // ************************************************************
    // serial register port
    // ************************************************************
    logic sck_q;
    logic cs_n_q;
    logic [39:0] shift_q;
    logic [5:0] bit_cnt_q;
    logic [31:0] rdata_q;
    logic sdo_q;
    logic [19:0] lower_thr_q;
    logic [19:0] upper_thr_q;
    logic [31:0] direct_cur_q;
    logic [22:0] min_comm_vel_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic dgram_done;
    logic [6:0] dgram_addr;
    logic [7:0] status_byte;

    assign sck_rise = spi_sck & ~sck_q;
    assign sck_fall = ~spi_sck & sck_q;
    assign cs_fall = ~spi_cs_n & cs_n_q;
    assign cs_rise = spi_cs_n & ~cs_n_q;
    assign dgram_done = cs_rise && bit_cnt_q == 6'(`DGRAM_BITS);
    assign dgram_addr = shift_q[`DGRAM_ADDR_MSB:`DGRAM_ADDR_LSB];

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sck_q <= spi_sck;
            cs_n_q <= spi_cs_n;
        end
    end

    // a short or long datagram is dropped whole
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= 40'h0000000000;
            bit_cnt_q <= 6'h00;
        end else if (cs_fall) begin
            shift_q <= {status_byte, rdata_q};
            bit_cnt_q <= 6'h00;
        end else if (sck_rise && !spi_cs_n) begin
            shift_q <= {shift_q[38:0], spi_sdi};
            if (bit_cnt_q != 6'h3f) begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdo_q <= 1'b0;
        end else if (cs_fall) begin
            sdo_q <= status_byte[7];
        end else if (sck_fall && !spi_cs_n) begin
            sdo_q <= shift_q[39];
        end
    end

    assign spi_sdo = sdo_q;
    assign spi_sdo_oe_n = spi_cs_n;

    // write-only registers read back as zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h00000000;
        end else if (dgram_done) begin
            rdata_q <= (dgram_addr == `ADDR_DIRECT_CUR) ? direct_cur_q : 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lower_thr_q <= `RST_LOWER_THR;
            upper_thr_q <= `RST_UPPER_THR;
            direct_cur_q <= `RST_DIRECT_CUR;
            min_comm_vel_q <= `RST_MIN_COMM_VEL;
        end else if (dgram_done && shift_q[`DGRAM_WRITE_BIT]) begin
            unique case (dgram_addr)
                `ADDR_LOWER_THR: lower_thr_q <= shift_q[19:0];
                `ADDR_UPPER_THR: upper_thr_q <= shift_q[19:0];
                `ADDR_DIRECT_CUR: direct_cur_q <= shift_q[31:0];
                `ADDR_MIN_COMM_VEL: min_comm_vel_q <= shift_q[22:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // threshold comparison
    // ************************************************************
    logic fast_lower_q;
    logic fast_upper_q;
    logic fast_pwm_q;
    logic [19:0] measured_step_interval_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fast_lower_q <= 1'b0;
            fast_upper_q <= 1'b0;
            fast_pwm_q <= 1'b0;
            measured_step_interval_q <= 20'hfffff;
        end else if (interval_valid) begin
            measured_step_interval_q <= measured_step_interval;
            fast_lower_q <= in_fast_region(fast_lower_q, measured_step_interval, lower_thr_q);
            fast_upper_q <= in_fast_region(fast_upper_q, measured_step_interval, upper_thr_q);
            fast_pwm_q <= in_fast_region(fast_pwm_q, measured_step_interval, pwm_upper_velocity_threshold);
        end
    end

    assign status_byte = {gates.stall_status_en, gates.fullstep_en, gates.pwm_mode_en, gates.adaptive_scale_en,
                          gates.commutation_en, coil_cmd.direct_drive_en, fast_upper_q, fast_lower_q};

    // ************************************************************
    // stall blanking after an upper threshold crossing
    // ************************************************************
    logic fast_upper_d1_q;
    logic [1:0] blank_cnt_q;
    logic blanking;

    // the crossing cycle itself is blanked too, before the counter is loaded
    assign blanking = blank_cnt_q != 2'h0 || fast_upper_q != fast_upper_d1_q;

    // counting three period edges gives two to three whole periods
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fast_upper_d1_q <= 1'b0;
            blank_cnt_q <= 2'h0;
        end else begin
            fast_upper_d1_q <= fast_upper_q;
            if (fast_upper_q != fast_upper_d1_q) begin
                blank_cnt_q <= `BLANK_PERIODS;
            end else if (blanking && elec_period_pulse) begin
                blank_cnt_q <= blank_cnt_q - 2'h1;
            end
        end
    end

    // ************************************************************
    // mode gates
    // ************************************************************
    logic direct_eff;
    logic step_ok;
    logic in_mid_band;
    logic [42:0] comm_product;
    mode_gates_t gates_d;

    assign direct_eff = cfg.direct_mode_sel & ~cfg.standalone_step_dir;
    assign step_ok = ~direct_eff | ext_step_active;
    assign in_mid_band = fast_lower_q & ~fast_upper_q;
    // velocity in units of 2^24 clocks is 2^24 / interval
    assign comm_product = {23'h000000, measured_step_interval_q} * {20'h00000, min_comm_vel_q};

    always_comb begin
        gates_d = '0;
        // commutation only runs faster than the pwm threshold; slower, voltage pwm owns the motor
        gates_d.commutation_en = commutation_enable_input & fast_pwm_q & ~direct_eff;
        gates_d.adaptive_scale_en = cfg.adaptive_scale_cfg & in_mid_band & step_ok;
        gates_d.stall_detect_en = (fast_lower_q | gates_d.commutation_en) & ~blanking & step_ok;
        gates_d.stall_status_en = cfg.stall_out_cfg & fast_lower_q & ~blanking & step_ok;
        gates_d.pwm_mode_en = cfg.pwm_mode_cfg & ~fast_pwm_q & ~fast_lower_q & ~fast_upper_q;
        gates_d.pwm_velocity_reg_en = gates_d.pwm_mode_en & ~direct_eff;
        gates_d.chopper_mode_force = fast_upper_q & cfg.high_speed_chopper;
        gates_d.fast_decay_zero = fast_upper_q & cfg.high_speed_chopper;
        gates_d.fullstep_en = fast_upper_q & cfg.high_speed_fullstep;
        gates_d.stall_from_commutation = fast_upper_q & cfg.high_speed_fullstep;
        gates_d.sync_eff = fast_upper_q ? 4'h0 : cfg.sync_cfg;
        gates_d.commutation_min_reached = gates_d.commutation_en &&
            comm_product > (43'h1 << `COMM_TREF_EXP);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gates <= '0;
        end else begin
            gates <= gates_d;
        end
    end

    // ************************************************************
    // direct coil current drive
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            coil_cmd <= '0;
        end else begin
            coil_cmd.direct_drive_en <= direct_eff;
            coil_cmd.coil_a <= direct_eff ?
                scale_coil(direct_cur_q[`COIL_A_MSB:`COIL_A_LSB], cfg.standstill_current) : 9'h000;
            coil_cmd.coil_b <= direct_eff ?
                scale_coil(direct_cur_q[`COIL_B_MSB:`COIL_B_LSB], cfg.standstill_current) : 9'h000;
        end
    end

    assign min_commutation_velocity = min_comm_vel_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_pwm_off_fast: assert property (fast_upper_q |=> !gates.pwm_mode_en)
        else $error("voltage pwm on above upper threshold");
    a_adapt_band: assert property (gates.adaptive_scale_en |-> $past(fast_lower_q) && !$past(fast_upper_q))
        else $error("adaptive scaling outside band");
    a_stall_slow_off: assert property (!fast_lower_q && !gates_d.commutation_en |=> !gates.stall_detect_en)
        else $error("stall detection on below lower threshold");
    a_blank_cross: assert property ($changed(fast_upper_q) |=> (!gates.stall_status_en && !gates.stall_detect_en) [*3])
        else $error("stall output not blanked after crossing");
    a_chop_force: assert property (fast_upper_q && cfg.high_speed_chopper |=>
        gates.chopper_mode_force && gates.fast_decay_zero)
        else $error("chopper not forced above upper threshold");
    a_sync_off: assert property (fast_upper_q |=> gates.sync_eff == 4'h0)
        else $error("sync not off above upper threshold");
    a_comm_pwm: assert property (gates.commutation_en |-> $past(fast_pwm_q) && $past(commutation_enable_input))
        else $error("commutation on in pwm region");
    a_direct_stand: assert property (cfg.standalone_step_dir |=> !coil_cmd.direct_drive_en && coil_cmd.coil_a == 9'h000)
        else $error("direct drive active in standalone mode");
    a_interval_hold: assert property (!interval_valid |=> $stable(fast_upper_q) && $stable(fast_lower_q))
        else $error("comparison changed without new interval");

    a_wr_lower: assert property (dgram_done && shift_q[`DGRAM_WRITE_BIT] &&
        dgram_addr == `ADDR_LOWER_THR |=> lower_thr_q == $past(shift_q[19:0]))
        else $error("lower threshold write lost");
    a_wr_upper: assert property (dgram_done && shift_q[`DGRAM_WRITE_BIT] &&
        dgram_addr == `ADDR_UPPER_THR |=> upper_thr_q == $past(shift_q[19:0]))
        else $error("upper threshold write lost");
    a_wr_direct: assert property (dgram_done && shift_q[`DGRAM_WRITE_BIT] &&
        dgram_addr == `ADDR_DIRECT_CUR |=> direct_cur_q == $past(shift_q[31:0]))
        else $error("direct coil current write lost");
    a_wr_min_vel: assert property (dgram_done && shift_q[`DGRAM_WRITE_BIT] &&
        dgram_addr == `ADDR_MIN_COMM_VEL |=> min_comm_vel_q == $past(shift_q[22:0]))
        else $error("minimum commutation velocity write lost");
    a_rd_direct: assert property (dgram_done && dgram_addr == `ADDR_DIRECT_CUR |=>
        rdata_q == $past(direct_cur_q))
        else $error("direct coil current read back wrong");

    a_lower_leave: assert property (interval_valid && measured_step_interval > lower_thr_q |=> !fast_lower_q)
        else $error("lower flag set above threshold");
    a_upper_leave: assert property (interval_valid && measured_step_interval > upper_thr_q |=> !fast_upper_q)
        else $error("upper flag set above threshold");
    a_lower_enter: assert property (interval_valid &&
        measured_step_interval < lower_thr_q - (lower_thr_q >> `HYST_SHIFT) |=> fast_lower_q)
        else $error("lower flag not set below hysteresis point");
    a_lower_stay: assert property (interval_valid && fast_lower_q && measured_step_interval <= lower_thr_q |=>
        fast_lower_q)
        else $error("lower flag dropped inside hysteresis band");

    a_stall_out_on: assert property (fast_lower_q && cfg.stall_out_cfg && !blanking && !direct_eff |=>
        gates.stall_status_en)
        else $error("stall output off at speed");
    a_stall_out_band: assert property (gates.stall_status_en |->
        $past(fast_lower_q) && $past(cfg.stall_out_cfg))
        else $error("stall output on below lower threshold");
    a_adapt_on: assert property (fast_lower_q && !fast_upper_q && cfg.adaptive_scale_cfg && !direct_eff |=>
        gates.adaptive_scale_en)
        else $error("adaptive scaling off inside band");
    a_pwm_band_off: assert property (fast_lower_q |=> !gates.pwm_mode_en)
        else $error("voltage pwm on inside band");
    a_pwm_slow_on: assert property (cfg.pwm_mode_cfg && !fast_pwm_q && !fast_lower_q && !fast_upper_q |=>
        gates.pwm_mode_en)
        else $error("voltage pwm off at low speed");
    a_fullstep_on: assert property (fast_upper_q && cfg.high_speed_fullstep |=>
        gates.fullstep_en && gates.stall_from_commutation)
        else $error("fullstep not applied above upper threshold");
    a_fast_only: assert property (!fast_upper_q |=> !gates.fullstep_en && !gates.chopper_mode_force)
        else $error("high speed override below upper threshold");
    a_sync_pass: assert property (!fast_upper_q |=> gates.sync_eff == $past(cfg.sync_cfg))
        else $error("sync setting not passed below upper threshold");
    a_comm_input: assert property (!commutation_enable_input |=> !gates.commutation_en)
        else $error("commutation on without enable input");
    a_comm_min: assert property (gates.commutation_min_reached |-> gates.commutation_en)
        else $error("minimum velocity flag outside commutation");
    a_direct_gates: assert property (direct_eff |=> !gates.commutation_en && !gates.pwm_velocity_reg_en)
        else $error("commutation or pwm regulation in direct mode");
    a_direct_step: assert property (direct_eff && !ext_step_active |=>
        !gates.adaptive_scale_en && !gates.stall_detect_en)
        else $error("scaling or stall on without step pulses");
    a_normal_coil: assert property (!direct_eff |=> coil_cmd == '0)
        else $error("coil command outside direct mode");

endmodule

// File: verilog/vsel_params.svh
/*
 * Constants of the velocity mode select block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 100 MHz driver clock and a 40-bit serial datagram.
 */
`ifndef VSEL_PARAMS_SVH
`define VSEL_PARAMS_SVH

`define CLK_PERIOD_NS 10
`define CLK_FREQ_HZ 100000000

// register offsets (7-bit address field of the datagram)
`define ADDR_LOWER_THR 7'h14
`define ADDR_UPPER_THR 7'h15
`define ADDR_DIRECT_CUR 7'h2d
`define ADDR_MIN_COMM_VEL 7'h33

// reset values
`define RST_LOWER_THR 20'h00000
`define RST_UPPER_THR 20'h00000
`define RST_DIRECT_CUR 32'h00000000
`define RST_MIN_COMM_VEL 23'h000000

// direct coil current fields
`define COIL_A_LSB 0
`define COIL_A_MSB 8
`define COIL_B_LSB 16
`define COIL_B_MSB 24

// serial datagram layout
`define DGRAM_BITS 40
`define DGRAM_WRITE_BIT 39
`define DGRAM_ADDR_MSB 38
`define DGRAM_ADDR_LSB 32

// threshold hysteresis: compare value minus compare value >> this shift
`define HYST_SHIFT 4
// electrical period edges counted while stall detection is blanked
`define BLANK_PERIODS 2'h3
// time reference exponent of the minimum commutation velocity
`define COMM_TREF_EXP 24
// standstill current scale: (setting + 1) / 2^shift
`define ISCALE_SHIFT 5

`endif

// File: verilog/vsel_pkg.sv
/*
 * Types of the velocity mode select block.
 * Assumes nothing beyond the constants header.
 */
package vsel_pkg;

    // velocity gated feature configuration from the driver setup
    typedef struct packed {
        logic adaptive_scale_cfg;
        logic stall_out_cfg;
        logic pwm_mode_cfg;
        logic high_speed_chopper;
        logic high_speed_fullstep;
        logic direct_mode_sel;
        logic standalone_step_dir;
        logic [3:0] sync_cfg;
        logic [4:0] standstill_current;
    } feature_cfg_t;

    // mode gates applied to the chopper and current control
    typedef struct packed {
        logic adaptive_scale_en;
        logic stall_detect_en;
        logic stall_status_en;
        logic stall_from_commutation;
        logic pwm_mode_en;
        logic pwm_velocity_reg_en;
        logic chopper_mode_force;
        logic fast_decay_zero;
        logic fullstep_en;
        logic commutation_en;
        logic commutation_min_reached;
        logic [3:0] sync_eff;
    } mode_gates_t;

    typedef struct packed {
        logic direct_drive_en;
        logic signed [8:0] coil_b;
        logic signed [8:0] coil_a;
    } coil_cmd_t;

endpackage

// File: tb/vsel_host.sv
/*
 * Host side of the serial register port: drives 40-bit datagrams, MSB first.
 * Assumes the design samples sck with ref_clk and needs two ref_clk per phase.
 */
`timescale 1ns/10ps
module vsel_host (
    input wire logic ref_clk,
    input wire logic spi_sdo,
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_sdi
);
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // four ref_clk per sck phase leave margin over the two-cycle sampling lag
    task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
        spi_cs_n <= 1'b0;
        for (int i = 39; i >= 0; i--) begin
            spi_sdi <= tx[i];
            wait_clk(4);
            spi_sck <= 1'b1;
            rx[i] = spi_sdo;
            wait_clk(4);
            spi_sck <= 1'b0;
        end
        wait_clk(4);
        spi_cs_n <= 1'b1;
        // released data line flips so a stale bit can never look valid
        spi_sdi <= ~tx[0];
        wait_clk(4);
    endtask
endmodule

// File: tb/velocity_mode_select_tb.sv
/*
 * Self-checking bench of the velocity mode select block.
 * Assumes the host model in vsel_host.sv and the constants header.
 */
`timescale 1ns/10ps
`include "vsel_params.svh"
module velocity_mode_select_tb;
    import vsel_pkg::*;
    logic ref_clk, arst_n, spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
    logic [19:0] measured_step_interval, pwm_thr;
    logic interval_valid, commutation_enable_input, ext_step_active, elec_period_pulse;
    feature_cfg_t cfg;
    mode_gates_t gates;
    coil_cmd_t coil_cmd;
    logic [22:0] min_vel;
    logic [39:0] rx;
    logic [31:0] d;
    int n_mismatch = 0;
    int checks_done = 0;

    vsel_host u_host (.ref_clk(ref_clk), .spi_sdo(spi_sdo), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi));

    velocity_mode_select u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
        .measured_step_interval(measured_step_interval), .interval_valid(interval_valid),
        .pwm_upper_velocity_threshold(pwm_thr), .cfg(cfg),
        .commutation_enable_input(commutation_enable_input), .ext_step_active(ext_step_active),
        .elec_period_pulse(elec_period_pulse), .gates(gates), .coil_cmd(coil_cmd),
        .min_commutation_velocity(min_vel));

    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        u_host.xfer({1'b1, a, v}, rx);
    endtask

    // read data of an address comes back in the following datagram
    task automatic rd(input logic [6:0] a, output logic [31:0] v);
        u_host.xfer({1'b0, a, 32'h00000000}, rx);
        u_host.xfer({1'b0, a, 32'h00000000}, rx);
        v = rx[31:0];
    endtask

    task automatic step(input logic [19:0] iv);
        measured_step_interval <= iv;
        interval_valid <= 1'b1;
        @(posedge ref_clk);
        interval_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic elec();
        elec_period_pulse <= 1'b1;
        @(posedge ref_clk);
        elec_period_pulse <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        arst_n = 1'b0;
        measured_step_interval = 20'hfffff;
        interval_valid = 1'b0;
        pwm_thr = 20'd5000;
        cfg = '0;
        commutation_enable_input = 1'b0;
        ext_step_active = 1'b0;
        elec_period_pulse = 1'b0;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        chk(gates, 32'h0);
        chk(coil_cmd, 32'h0);
        chk(spi_sdo_oe_n, 1'b1);
        // coil values kept within 248 as the host must
        wr(`ADDR_DIRECT_CUR, 32'h00f80108);
        wr(`ADDR_LOWER_THR, 32'd1000);
        wr(`ADDR_UPPER_THR, 32'd200);
        wr(`ADDR_MIN_COMM_VEL, 32'h007fffff);
        chk(min_vel, 32'h007fffff);
        rd(`ADDR_DIRECT_CUR, d);
        chk(d, 32'h00f80108);
        rd(`ADDR_LOWER_THR, d);
        chk(d, 32'h0);
        rd(7'h7f, d);
        chk(d, 32'h0);
        // adaptive, stall out, pwm, chopper and fullstep flags on, sync 5
        cfg <= {5'h1f, 1'b0, 1'b0, 4'h5, 5'h00};
        step(20'd8000);
        chk(gates.pwm_mode_en, 1);
        chk(gates.pwm_velocity_reg_en, 1);
        chk(gates.adaptive_scale_en, 0);
        chk(gates.stall_detect_en, 0);
        step(20'd950);
        chk(gates.stall_status_en, 0);
        chk(gates.pwm_mode_en, 0);
        step(20'd900);
        chk(gates.stall_status_en, 1);
        chk(gates.adaptive_scale_en, 1);
        chk(gates.sync_eff, 5);
        step(20'd1000);
        chk(gates.stall_status_en, 1);
        step(20'd1001);
        chk(gates.stall_status_en, 0);
        chk(gates.stall_detect_en, 0);
        step(20'd500);
        commutation_enable_input <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(gates.commutation_en, 1);
        chk(gates.commutation_min_reached, 1);
        step(20'd150);
        chk(gates.adaptive_scale_en, 0);
        chk(gates.pwm_mode_en, 0);
        chk(gates.chopper_mode_force, 1);
        chk(gates.fast_decay_zero, 1);
        chk(gates.sync_eff, 0);
        chk(gates.fullstep_en, 1);
        chk(gates.stall_from_commutation, 1);
        chk(gates.stall_status_en, 0);
        repeat (3) elec();
        chk(gates.stall_status_en, 1);
        step(20'd500);
        // direct drive at half standstill scale: 248 * 16 / 32 = 124
        cfg <= {5'h1f, 1'b1, 1'b0, 4'h5, 5'h0f};
        repeat (3) @(posedge ref_clk);
        chk(coil_cmd, {13'h0, 1'b1, 9'h07c, 9'h184});
        chk(gates.commutation_en, 0);
        chk(gates.adaptive_scale_en, 0);
        ext_step_active <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(gates.adaptive_scale_en, 1);
        cfg <= {5'h1f, 1'b1, 1'b1, 4'h5, 5'h0f};
        repeat (3) @(posedge ref_clk);
        chk(coil_cmd, 32'h0);
        wrap_up();
    end
endmodule
